/* File: src/noise_filter.v */
// four-sample agreement filter for the capture trigger
// assumes sample_in is already synchronised to sys_clk
`timescale 1ns/1ps
`include "timer16_defines.vh"

module noise_filter #(
   parameter SAMPLES = `FILTER_SAMPLES
) (
   input wire sys_clk,
   input wire rst_b,
   input wire enable,
   input wire sample_in,
   output wire filtered
);

   reg [SAMPLES-1:0] hist_q;
   reg out_q;

   wire all_high = &hist_q;
   wire all_low = ~|hist_q;

   // sample history runs on the undivided clock, output moves only on agreement while enabled
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         hist_q <= {SAMPLES{1'b0}};
         out_q <= 1'b0;
      end else begin
         hist_q <= {hist_q[SAMPLES-2:0], sample_in};
         if (!enable)
            out_q <= sample_in; // bypass: one register stage only
         else if (all_high)
            out_q <= 1'b1;
         else if (all_low)
            out_q <= 1'b0;
      end
   end

   assign filtered = out_q;

endmodule // noise_filter

/* File: src/timer16_capture_compare.v */
// capture and compare logic beside a 16-bit timer, with an ahb-lite register slave
// assumes the counter unit outside supplies value, tick, top/bottom and cpu-write pulse
//
// Overview of operation
// - capture trigger: pin, or comparator when selected
// - source switch may cause a capture
// - filter output moves after four agreeing samples
// - filter adds four system clock cycles
// - filter samples on undivided system clock
// - capture input off in capture-top modes
// - software-driven pin level can trigger capture
// - each capture overwrites the capture value
// - match sets compare flag next tick
// - enabled flag requests irq, cleared by service
// - channel a value exported as top
// - pwm modes buffer compare, update top/bottom
// - cpu reaches buffer or active register
// - compare high byte reads directly
// - high byte to temp, low write loads
// - force strobe acts on output only
// - counter write blocks next tick's match
// - counter written at top skips match
// - compare output kept across mode change
// - output mode bits act immediately
// - capture and flag in same cycle
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "timer16_defines.vh"

module timer16_capture_compare #(
   parameter FILTER_SAMPLES = `FILTER_SAMPLES
) (
   input wire sys_clk,
   input wire rst_b,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire capture_pin,
   input wire comparator_output,
   input wire [15:0] counter_value,
   input wire timer_tick,
   input wire counter_write,
   input wire count_top,
   input wire count_bottom,
   input wire [2:0] irq_ack,
   output wire capture_irq,
   output wire compare_irq_a,
   output wire compare_irq_b,
   output wire compare_output_a,
   output wire compare_output_b,
   output wire [15:0] top_value_a,
   output wire [15:0] capture_value
);

   // bus state
   reg data_q;
   reg wr_q;
   reg [7:0] addr_q;
   reg hreadyout_q;
   reg [31:0] hrdata_q;
   // control registers
   reg [7:0] timer_ctrl_a_q;
   reg [7:0] timer_ctrl_b_q;
   reg comp_sel_q;
   reg [2:0] mask_q;
   reg [7:0] temp_q;
   // capture state
   reg pin_s1_q;
   reg pin_s2_q;
   reg cmp_s1_q;
   reg cmp_s2_q;
   reg filt_prev_q;
   reg [15:0] capture_value_q;
   reg capture_flag_q;
   reg capture_irq_q;
   reg block_q;
   reg [7:0] rd_byte;

   wire filt;
   wire [1:0] cmp_flag;
   wire [1:0] cmp_oc;
   wire [1:0] cmp_irq;
   wire [31:0] cmp_view;
   wire [15:0] act_a;

   // bus strobes for the address and data phases
   wire bus_take = hsel & hready & htrans[1];
   wire wr_go = data_q & wr_q;
   wire rd_go = data_q & ~wr_q;
   wire [7:0] wbyte = hwdata[7:0];
   wire flag_wr = wr_go & (addr_q == `REG_TIMER_FLAG);

   // mode decode
   wire [3:0] wave = timer_ctrl_b_q[`CTRL_B_WAVE_HI -: 4];
   wire pwm_mode = ~((wave == `WAVE_NORMAL) | (wave == `WAVE_CTC_CMP) |
                     (wave == `WAVE_CTC_CAP) | (wave == `WAVE_RESERVED));
   wire cap_top = (wave == `WAVE_PFC_CAP) | (wave == `WAVE_PC_CAP) |
                  (wave == `WAVE_CTC_CAP) | (wave == `WAVE_FAST_CAP);
   wire upd_bottom = (wave == `WAVE_PFC_CAP) | (wave == `WAVE_PFC_CMP);
   wire buf_upd = pwm_mode & timer_tick & (upd_bottom ? count_bottom : count_top);

   // switching is not masked, edge may follow
   wire trig = comp_sel_q ? cmp_s2_q : pin_s2_q;

   // edge detection after the filter
   wire rise = filt & ~filt_prev_q;
   wire fall = ~filt & filt_prev_q;
   // capture off when capture value is top
   wire cap_evt = ~cap_top & (timer_ctrl_b_q[`CTRL_B_EDGE_RISE] ? rise : fall);

   // both inputs pass two flops whatever drives them
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         cmp_s1_q <= 1'b0;
         cmp_s2_q <= 1'b0;
         filt_prev_q <= 1'b0;
      end else begin
         pin_s1_q <= capture_pin;
         pin_s2_q <= pin_s1_q;
         cmp_s1_q <= comparator_output;
         cmp_s2_q <= cmp_s1_q;
         filt_prev_q <= filt;
      end
   end

   // runs on sys_clk, not the tick
   noise_filter #(
      .SAMPLES(FILTER_SAMPLES)
   ) u_filter (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .enable(timer_ctrl_b_q[`CTRL_B_FILTER_EN]),
      .sample_in(trig),
      .filtered(filt)
   );

   // ahb-lite slave: one wait state, always okay
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         data_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= `RST_BYTE;
         hreadyout_q <= 1'b1;
         hrdata_q <= 32'h0000_0000;
      end else begin
         if (data_q) begin
            data_q <= 1'b0;
            hreadyout_q <= 1'b1;
            if (rd_go)
               hrdata_q <= {24'h00_0000, rd_byte};
         end else if (bus_take) begin
            data_q <= 1'b1;
            wr_q <= hwrite;
            addr_q <= haddr[7:0];
            hreadyout_q <= 1'b0;
         end
      end
   end

   // read data mux
   always @* begin
      case (addr_q)
         `REG_TIMER_CTRL_A: rd_byte = timer_ctrl_a_q;
         `REG_TIMER_CTRL_B: rd_byte = timer_ctrl_b_q;
         `REG_COMP_CTRL: rd_byte = {2'b00, cmp_s2_q, 2'b00, comp_sel_q, 2'b00};
         `REG_CAPTURE_LOW: rd_byte = capture_value_q[7:0];
         `REG_CAPTURE_HIGH: rd_byte = temp_q;
         `REG_CMP_A_LOW: rd_byte = cmp_view[7:0];
         // high byte read straight from register
         `REG_CMP_A_HIGH: rd_byte = cmp_view[15:8];
         `REG_CMP_B_LOW: rd_byte = cmp_view[23:16];
         `REG_CMP_B_HIGH: rd_byte = cmp_view[31:24];
         `REG_TIMER_FLAG: rd_byte = {5'b00000, cmp_flag, capture_flag_q};
         `REG_TIMER_IRQ_MASK: rd_byte = {5'b00000, mask_q};
         default: rd_byte = `RST_BYTE;
      endcase
   end

   // control registers and the shared high-byte holder
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         timer_ctrl_a_q <= `RST_BYTE;
         timer_ctrl_b_q <= `RST_BYTE;
         comp_sel_q <= 1'b0;
         mask_q <= 3'b000;
         temp_q <= `RST_BYTE;
      end else begin
         if (wr_go) begin
            case (addr_q)
               // output mode used from the next cycle on
               `REG_TIMER_CTRL_A: timer_ctrl_a_q <= wbyte;
               `REG_TIMER_CTRL_B: timer_ctrl_b_q <= wbyte;
               `REG_COMP_CTRL: comp_sel_q <= wbyte[`COMP_SEL_BIT];
               `REG_TIMER_IRQ_MASK: mask_q <= wbyte[2:0];
               // high bytes land in the holder
               `REG_CAPTURE_HIGH: temp_q <= wbyte;
               `REG_CMP_A_HIGH: temp_q <= wbyte;
               `REG_CMP_B_HIGH: temp_q <= wbyte;
               default: temp_q <= temp_q;
            endcase
         end else if (rd_go && addr_q == `REG_CAPTURE_LOW) begin
            temp_q <= capture_value_q[15:8]; // low read freezes the high byte
         end
      end
   end

   // capture register, flag and request
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         capture_value_q <= `RST_WORD;
         capture_flag_q <= 1'b0;
         capture_irq_q <= 1'b0;
      end else begin
         // value and flag in one cycle
         if (cap_evt)
            capture_value_q <= counter_value;
         else if (cap_top && wr_go && addr_q == `REG_CAPTURE_LOW)
            capture_value_q <= {temp_q, wbyte};
         // set beats write-one clear and service
         if (cap_evt)
            capture_flag_q <= 1'b1;
         else if ((flag_wr & wbyte[`FLAG_CAPTURE]) | irq_ack[`FLAG_CAPTURE])
            capture_flag_q <= 1'b0;
         capture_irq_q <= capture_flag_q & mask_q[`FLAG_CAPTURE];
      end
   end

   // cpu write to counter blocks the next tick
   // a counter write equal to top loses that match
   always @(posedge sys_clk) begin
      if (!rst_b)
         block_q <= 1'b0;
      else if (counter_write)
         block_q <= 1'b1;
      else if (timer_tick)
         block_q <= 1'b0;
   end

   // two compare channels
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_cmp
         reg [15:0] act_q;
         reg [15:0] buf_q;
         reg oc_q;
         reg flag_q;
         reg irq_q;
         reg oc_d;
         wire [7:0] lo_addr = (g == 0) ? `REG_CMP_A_LOW : `REG_CMP_B_LOW;
         wire [1:0] com = timer_ctrl_a_q[`CTRL_A_COM_A_HI - 2 * g -: 2];
         wire lo_wr = wr_go & (addr_q == lo_addr);
         wire hit = timer_tick & (counter_value == act_q) & ~block_q;
         wire force_hit = wr_go & (addr_q == `REG_TIMER_CTRL_C) & ~pwm_mode &
                          wbyte[`CTRL_C_FORCE_A - g];
         wire restart = pwm_mode & timer_tick & count_bottom;
         wire clr = (flag_wr & wbyte[`FLAG_CMP_A + g]) | irq_ack[`FLAG_CMP_A + g];

         // next compare output level
         always @* begin
            oc_d = oc_q;
            if (hit | force_hit) begin
               case (com)
                  `COM_TOGGLE: oc_d = pwm_mode ? oc_q : ~oc_q;
                  `COM_CLEAR: oc_d = 1'b0;
                  `COM_SET: oc_d = 1'b1;
                  default: oc_d = oc_q;
               endcase
            end else if (restart) begin
               case (com)
                  `COM_CLEAR: oc_d = 1'b1;
                  `COM_SET: oc_d = 1'b0;
                  default: oc_d = oc_q;
               endcase
            end
         end

         // compare value, flag, output and request
         always @(posedge sys_clk) begin
            if (!rst_b) begin
               act_q <= `RST_WORD;
               buf_q <= `RST_WORD;
               oc_q <= 1'b0;
               flag_q <= 1'b0;
               irq_q <= 1'b0;
            end else begin
               // low write loads all 16 bits at once
               // buffer in every mode, active as well outside pwm modes
               if (lo_wr)
                  buf_q <= {temp_q, wbyte};
               if (lo_wr && !pwm_mode)
                  act_q <= {temp_q, wbyte};
               else if (buf_upd)
                  act_q <= buf_q;
               // output held, only actions change it
               oc_q <= oc_d;
               // flag set at the tick ending the match cycle
               if (hit)
                  flag_q <= 1'b1;
               else if (clr)
                  flag_q <= 1'b0;
               irq_q <= flag_q & mask_q[`FLAG_CMP_A + g];
            end
         end

         assign cmp_view[16 * g +: 16] = pwm_mode ? buf_q : act_q;
         assign cmp_flag[g] = flag_q;
         assign cmp_oc[g] = oc_q;
         assign cmp_irq[g] = irq_q;
      end
   endgenerate

   // channel a active value offered as counter top
   assign act_a = g_cmp[0].act_q;

   // outputs from flops, except hresp tied to a constant
   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0; // constant okay response
   assign capture_irq = capture_irq_q;
   assign compare_irq_a = cmp_irq[0];
   assign compare_irq_b = cmp_irq[1];
   assign compare_output_a = cmp_oc[0];
   assign compare_output_b = cmp_oc[1];
   assign top_value_a = act_a;
   assign capture_value = capture_value_q;

endmodule // timer16_capture_compare

/* File: src/timer16_defines.vh */
// constants of the 16-bit timer capture/compare block
// assumes word-aligned register map on a 32-bit bus, byte data in bits 7:0
`ifndef TIMER16_DEFINES_VH
`define TIMER16_DEFINES_VH

// register byte offsets
`define REG_TIMER_CTRL_A 8'h00
`define REG_TIMER_CTRL_B 8'h04
`define REG_TIMER_CTRL_C 8'h08
`define REG_COMP_CTRL 8'h0C
`define REG_CAPTURE_LOW 8'h10
`define REG_CAPTURE_HIGH 8'h14
`define REG_CMP_A_LOW 8'h18
`define REG_CMP_A_HIGH 8'h1C
`define REG_CMP_B_LOW 8'h20
`define REG_CMP_B_HIGH 8'h24
`define REG_TIMER_FLAG 8'h28
`define REG_TIMER_IRQ_MASK 8'h2C

// timer_ctrl_a fields: compare_output_mode of channel a and b
`define CTRL_A_COM_A_HI 7
`define CTRL_A_COM_B_HI 5
// timer_ctrl_b fields
`define CTRL_B_FILTER_EN 7
`define CTRL_B_EDGE_RISE 6
`define CTRL_B_WAVE_HI 3
// timer_ctrl_c force strobes
`define CTRL_C_FORCE_A 7
`define CTRL_C_FORCE_B 6
// comparator_ctrl_status fields
`define COMP_OUT_BIT 5
`define COMP_SEL_BIT 2
// flag and mask bit positions
`define FLAG_CAPTURE 0
`define FLAG_CMP_A 1
`define FLAG_CMP_B 2

// waveform modes
`define WAVE_NORMAL 4'h0
`define WAVE_CTC_CMP 4'h4
`define WAVE_CTC_CAP 4'hC
`define WAVE_RESERVED 4'hD
`define WAVE_PFC_CAP 4'h8
`define WAVE_PFC_CMP 4'h9
`define WAVE_PC_CAP 4'hA
`define WAVE_FAST_CAP 4'hE

// compare output actions
`define COM_OFF 2'h0
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3

// reset values and counts
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define FILTER_SAMPLES 4

`endif

/* File: verif/event_source_model.sv */
// model of the trigger sources: capture pin and comparator output
// assumes callers sit just past a rising edge of sys_clk
`timescale 1ns/1ps
module event_source_model (
   input wire sys_clk,
   output reg capture_pin,
   output reg comparator_output
);
   // both sources idle low
   initial begin
      capture_pin = 1'h0;
      comparator_output = 1'h0;
   end

   // pin or comparator level from software
   // a level change lands right after an edge and then holds
   task drive_level(input comp, input lvl);
      begin
         @(posedge sys_clk);
         if (comp)
            comparator_output <= lvl;
         else
            capture_pin <= lvl;
      end
   endtask
endmodule // event_source_model

/* File: verif/test_timer16_capture_compare.sv */
// self-checking bench for the capture/compare block
// assumes the trigger model beside it and the bound checker
`timescale 1ns/1ps
`include "timer16_defines.vh"
module test_timer16_capture_compare;
   reg sys_clk;
   reg rst_b;
   reg hsel;
   reg hwrite;
   reg [1:0] htrans;
   reg [2:0] hsize;
   reg [31:0] haddr;
   reg [31:0] hwdata;
   reg [15:0] counter_value;
   reg timer_tick;
   reg counter_write;
   reg count_top;
   reg count_bottom;
   reg [2:0] irq_ack;
   reg [31:0] rd;
   reg [2:0] rows [0:4];
   wire [31:0] hrdata;
   wire hreadyout;
   wire hresp;
   wire capture_pin;
   wire comparator_output;
   wire capture_irq;
   wire compare_irq_a;
   wire compare_irq_b;
   wire compare_output_a;
   wire compare_output_b;
   wire [15:0] top_value_a;
   wire [15:0] capture_value;
   int mismatches;
   int compares;
   int n_off;
   int n_on;
   int n;
   int i;

   timer16_capture_compare #(.FILTER_SAMPLES(4)) dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .capture_pin(capture_pin), .comparator_output(comparator_output),
      .counter_value(counter_value), .timer_tick(timer_tick),
      .counter_write(counter_write), .count_top(count_top),
      .count_bottom(count_bottom), .irq_ack(irq_ack), .capture_irq(capture_irq),
      .compare_irq_a(compare_irq_a), .compare_irq_b(compare_irq_b),
      .compare_output_a(compare_output_a), .compare_output_b(compare_output_b),
      .top_value_a(top_value_a), .capture_value(capture_value)
   );

   event_source_model src (
      .sys_clk(sys_clk),
      .capture_pin(capture_pin),
      .comparator_output(comparator_output)
   );

   task chk(input [31:0] seen, input [31:0] exp, input [8*10:1] nm);
      begin
         compares++;
         if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask

   // one single transfer: address phase, then data phase, read data in rd
   task bus(input [7:0] a, input w, input [7:0] d);
      begin
         htrans <= 2'h2;
         haddr <= {24'h00_0000, a};
         hwrite <= w;
         @(posedge sys_clk);
         while (hreadyout !== 1'h1) @(posedge sys_clk);
         htrans <= 2'h0;
         hwdata <= {24'h00_0000, d};
         @(posedge sys_clk);
         while (hreadyout !== 1'h1) @(posedge sys_clk);
         rd = hrdata;
      end
   endtask

   // one timer clock, outputs settled two edges later
   task tick(input top);
      begin
         timer_tick <= 1'h1;
         count_top <= top;
         @(posedge sys_clk);
         timer_tick <= 1'h0;
         count_top <= 1'h0;
         repeat (2) @(posedge sys_clk);
      end
   endtask

   task ack(input [2:0] v);
      begin
         irq_ack <= v;
         @(posedge sys_clk);
         irq_ack <= 3'h0;
         repeat (2) @(posedge sys_clk);
      end
   endtask

   // move a trigger source and count edges until the capture value moves
   task cap(input [15:0] cv, input comp, input lvl, output int k);
      reg [15:0] old;
      begin
         old = capture_value;
         counter_value <= cv;
         src.drive_level(comp, lvl);
         k = 0;
         while (capture_value === old && k < 16) begin
            @(posedge sys_clk);
            k++;
         end
      end
   endtask

   task test_done;
      begin
         $display("compares %0d mismatches %0d", compares, mismatches);
         if (mismatches == 0 && compares > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask

   initial begin
      sys_clk = 1'h0;
      forever #2 sys_clk = ~sys_clk;
   end

   // hang guard
   initial begin
      #40000;
      mismatches++;
      test_done;
   end

   initial begin
      {rst_b, hwrite, timer_tick, counter_write, count_top, count_bottom} = 6'h00;
      hsel = 1'h1;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      counter_value = 16'h1234;
      irq_ack = 3'h0;
      rows = '{3'h7, 3'h2, 3'h3, 3'h4, 3'h0};
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'h1;
      @(posedge sys_clk);
      chk(capture_value, 16'h0000, "cap_rst");
      chk(hreadyout, 1'h1, "rdy_rst");
      bus(`REG_TIMER_IRQ_MASK, 1'h1, 8'h07);
      bus(8'h30, 1'h0, 8'h00);
      chk(rd, 32'h0000_0000, "unmapped");
      // high byte once, reused for channel b
      bus(`REG_CMP_A_HIGH, 1'h1, 8'h12);
      bus(`REG_CMP_A_LOW, 1'h1, 8'h34);
      bus(`REG_CMP_B_LOW, 1'h1, 8'h34);
      chk(top_value_a, 16'h1234, "cmp_a");
      bus(`REG_CMP_A_HIGH, 1'h0, 8'h00);
      chk(rd, 32'h0000_0012, "cmp_a_hi");
      bus(`REG_CMP_B_HIGH, 1'h0, 8'h00);
      chk(rd, 32'h0000_0012, "cmp_b_hi");
      $display("test registers done");
      // each output action on both channels at a match, then service
      for (i = 0; i < 5; i++) begin
         bus(`REG_TIMER_CTRL_A, 1'h1, {rows[i][2:1], rows[i][2:1], 4'h0});
         tick(1'h0);
         chk(compare_output_a, rows[i][0], "out_a");
         chk(compare_output_b, rows[i][0], "out_b");
         chk(compare_irq_b, 1'h1, "irq_b");
         ack(3'h6);
         chk(compare_irq_a, 1'h0, "irq_a_clr");
      end
      counter_write <= 1'h1;
      @(posedge sys_clk);
      counter_write <= 1'h0;
      tick(1'h0);
      chk(compare_irq_a, 1'h0, "blocked");
      tick(1'h0);
      chk(compare_irq_a, 1'h1, "unblocked");
      ack(3'h6);
      bus(`REG_TIMER_CTRL_A, 1'h1, 8'hF0);
      bus(`REG_TIMER_CTRL_C, 1'h1, 8'hC0);
      repeat (2) @(posedge sys_clk);
      chk(compare_output_a, 1'h1, "forced");
      chk(compare_output_b, 1'h1, "forced_b");
      chk(compare_irq_a, 1'h0, "force_flag");
      $display("test compare done");
      bus(`REG_TIMER_CTRL_B, 1'h1, 8'h40);
      cap(16'h0101, 1'h0, 1'h1, n_off);
      chk(capture_value, 16'h0101, "cap_rise");
      cap(16'h0202, 1'h0, 1'h0, n);
      chk(capture_value, 16'h0101, "cap_fall");
      bus(`REG_TIMER_CTRL_B, 1'h1, 8'hC0);
      src.drive_level(1'h0, 1'h1);
      repeat (2) @(posedge sys_clk);
      cap(16'h0222, 1'h0, 1'h0, n);
      chk(capture_value, 16'h0101, "glitch");
      cap(16'h0303, 1'h0, 1'h1, n_on);
      chk(capture_value, 16'h0303, "overwrite");
      chk(n_on - n_off, 4, "filt_lat");
      bus(`REG_TIMER_CTRL_B, 1'h1, 8'h80);
      cap(16'h0404, 1'h0, 1'h0, n);
      chk(capture_value, 16'h0404, "fall_mode");
      bus(`REG_TIMER_CTRL_B, 1'h1, 8'h40);
      cap(16'h05A5, 1'h1, 1'h1, n);
      chk(capture_value, 16'h0404, "comp_off");
      bus(`REG_COMP_CTRL, 1'h1, 8'h04);
      repeat (8) @(posedge sys_clk);
      chk(capture_value, 16'h05A5, "src_swap");
      // low byte read freezes the high byte for the later high read
      bus(`REG_CAPTURE_LOW, 1'h0, 8'h00);
      chk(rd, 32'h0000_00A5, "cap_lo");
      bus(`REG_CAPTURE_HIGH, 1'h0, 8'h00);
      chk(rd, 32'h0000_0005, "cap_hi");
      bus(`REG_TIMER_FLAG, 1'h1, 8'h01);
      repeat (2) @(posedge sys_clk);
      chk(capture_irq, 1'h0, "cap_clr");
      $display("test capture done");
      bus(`REG_TIMER_CTRL_B, 1'h1, 8'h0E);
      chk(compare_output_a, 1'h1, "out_kept");
      bus(`REG_CMP_A_HIGH, 1'h1, 8'h00);
      bus(`REG_CMP_A_LOW, 1'h1, 8'h55);
      chk(top_value_a, 16'h1234, "buffered");
      counter_value <= 16'h0700;
      tick(1'h1);
      chk(top_value_a, 16'h0055, "buf_load");
      // set-on-match output returns low at the bottom
      count_bottom <= 1'h1;
      tick(1'h0);
      count_bottom <= 1'h0;
      chk(compare_output_a, 1'h0, "pwm_bottom");
      src.drive_level(1'h1, 1'h0);
      cap(16'h0707, 1'h1, 1'h1, n);
      chk(capture_value, 16'h05A5, "cap_off");
      $display("test pwm done");
      test_done;
   end
endmodule // test_timer16_capture_compare

/* File: verif/timer16_capture_compare_monitor.sv */
// checker on the ports of the capture/compare block
// assumes hready is fed back from hreadyout, single clock domain
`timescale 1ns/1ps
module timer16_capture_compare_monitor #(
   parameter FILTER_SAMPLES = 4
) (
   input wire sys_clk,
   input wire rst_b,
   input wire hsel,
   input wire [1:0] htrans,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   input wire timer_tick,
   input wire counter_write,
   input wire [2:0] irq_ack,
   input wire capture_irq,
   input wire compare_irq_a,
   input wire compare_irq_b,
   input wire [15:0] capture_value
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   reg blk_q;

   // remembers a counter write until the next timer tick
   always @(posedge sys_clk) begin
      if (!rst_b)
         blk_q <= 1'h0;
      else if (counter_write)
         blk_q <= 1'h1;
      else if (timer_tick)
         blk_q <= 1'h0;
   end

   sequence s_take;
      hsel && hready && htrans[1] && hreadyout;
   endsequence
   sequence s_wait;
      !hreadyout ##1 hreadyout;
   endsequence

   a_bus_wait: assert property (s_take |=> s_wait)
      else $error("bus wait state not exactly one cycle");
   a_resp_okay: assert property (hresp == 1'h0)
      else $error("bus response not okay");
   a_rdata_upper: assert property (hrdata[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
   a_irq_a_cause: assert property ($rose(compare_irq_a) |-> $past(timer_tick, 2))
      else $error("compare a request without a tick");
   a_irq_b_cause: assert property ($rose(compare_irq_b) |-> $past(timer_tick, 2))
      else $error("compare b request without a tick");
   a_cap_irq_load: assert property ($changed(capture_value) |=> capture_irq)
      else $error("capture load without capture request");
   a_irq_a_ack: assert property (irq_ack[1] && !timer_tick |-> ##2 !compare_irq_a)
      else $error("compare a request not cleared by service");
   a_block_match: assert property (timer_tick && blk_q |->
      ##2 !$rose(compare_irq_a) && !$rose(compare_irq_b))
      else $error("match not blocked after counter write");
endmodule // timer16_capture_compare_monitor

bind timer16_capture_compare timer16_capture_compare_monitor #(
   .FILTER_SAMPLES(FILTER_SAMPLES)
) u_monitor (
   .sys_clk(sys_clk),
   .rst_b(rst_b),
   .hsel(hsel),
   .htrans(htrans),
   .hready(hready),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .hrdata(hrdata),
   .timer_tick(timer_tick),
   .counter_write(counter_write),
   .irq_ack(irq_ack),
   .capture_irq(capture_irq),
   .compare_irq_a(compare_irq_a),
   .compare_irq_b(compare_irq_b),
   .capture_value(capture_value)
);
